// File: rtl/drive_serial_command_words.sv
// serial command, setpoint and speed monitor words of the drive
module drive_serial_command_words (
	// clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        ce_in,
	// parameter access port
	input  wire logic        param_wr_in,
	input  wire logic        param_rd_in,
	input  wire logic        param_serial_src_in,
	input  wire logic [1:0]  param_sel_in,
	input  wire logic [15:0] param_wdata_in,
	output logic      [15:0] param_rdata_out,
	output logic             param_ack_out,
	output logic             param_refused_out,
	// source configuration
	input  wire logic        cmd_source_serial_in,
	input  wire logic        ref_source_serial_in,
	// drive state
	input  wire logic [15:0] motor_freq_in,
	input  wire logic        motor_reverse_in,
	input  wire logic [15:0] rated_motor_frequency_in,
	input  wire logic        fault_active_in,
	// command outputs
	output logic             run_out,
	output logic             enable_out,
	output logic             inching_function_out,
	output logic             local_remote_select_out,
	output logic             second_ramp_out,
	output logic             fault_reset_out,
	output logic      [7:0]  binary_object_mirror_out,
	// speed reference outputs
	output logic      [17:0] ref_freq_out,
	output logic             ref_forward_out,
	output logic             ref_valid_out,
	// speed monitor
	output logic      [15:0] motor_speed_monitor_out
);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	// parameter storage
	logic [15:0] command_r;
	logic [15:0] command_nxt;
	logic [15:0] setpoint_r;
	logic [15:0] setpoint_nxt;
	logic [15:0] rdata_nxt;
	logic        ack_nxt;
	logic        refused_nxt;

	// divider state
	drive_serial_pkg::div_state_e div_state_r;
	drive_serial_pkg::div_state_e div_state_nxt;
	logic [28:0] dvd_r;
	logic [28:0] dvd_nxt;
	logic [28:0] quo_r;
	logic [28:0] quo_nxt;
	logic [16:0] rem_r;
	logic [16:0] rem_nxt;
	logic [15:0] den_r;
	logic [15:0] den_nxt;
	logic        rev_r;
	logic        rev_nxt;
	logic [4:0]  cnt_r;
	logic [4:0]  cnt_nxt;
	logic [15:0] speed_nxt;

	// command and reference outputs
	logic        run_nxt;
	logic        enable_nxt;
	logic        inching_nxt;
	logic        remote_nxt;
	logic        ramp2_nxt;
	logic        fault_rst_nxt;
	logic        fault_cond_r;
	logic        fault_cond_nxt;
	logic [7:0]  mirror_nxt;
	logic [17:0] ref_freq_nxt;
	logic        ref_fwd_nxt;
	logic        ref_valid_nxt;

	// helpers
	logic [16:0] rem_shift;
	logic [16:0] rem_sub;
	logic [16:0] ref_mag;
	logic [32:0] ref_prod;
	logic        wr_ok;

	// write is accepted only from the serial source and a writable word
	assign wr_ok = param_wr_in && param_serial_src_in &&
		(param_sel_in == drive_serial_pkg::SEL_COMMAND ||
		 param_sel_in == drive_serial_pkg::SEL_SETPOINT);

	// parameter access: writes, reads, acknowledge
	always_comb begin
		command_nxt  = command_r;
		setpoint_nxt = setpoint_r;
		rdata_nxt    = param_rdata_out;
		ack_nxt      = 1'b0;
		refused_nxt  = 1'b0;
		if (param_wr_in) begin
			ack_nxt     = 1'b1;
			refused_nxt = !wr_ok;
			if (wr_ok && param_sel_in == drive_serial_pkg::SEL_COMMAND) begin
				// reserved bits never stored, so they always read zero
				command_nxt = param_wdata_in &
					drive_serial_pkg::COMMAND_MASK;
			end
			if (wr_ok && param_sel_in == drive_serial_pkg::SEL_SETPOINT) begin
				setpoint_nxt = param_wdata_in;
			end
		end else if (param_rd_in) begin
			ack_nxt = 1'b1;
			case (param_sel_in)
				drive_serial_pkg::SEL_SPEED_MON: begin
					rdata_nxt = motor_speed_monitor_out;
				end
				drive_serial_pkg::SEL_COMMAND: begin
					rdata_nxt = command_r;
				end
				drive_serial_pkg::SEL_SETPOINT: begin
					rdata_nxt = setpoint_r;
				end
				default: begin
					rdata_nxt   = 16'h0000;
					refused_nxt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			command_r         <= drive_serial_pkg::COMMAND_RESET;
			setpoint_r        <= drive_serial_pkg::SETPOINT_RESET;
			param_rdata_out   <= 16'h0000;
			param_ack_out     <= 1'b0;
			param_refused_out <= 1'b0;
		end else if (ce_in) begin
			command_r         <= command_nxt;
			setpoint_r        <= setpoint_nxt;
			param_rdata_out   <= rdata_nxt;
			param_ack_out     <= ack_nxt;
			param_refused_out <= refused_nxt;
		end
	end

	// one restoring step of speed = freq * 8192 / rated
	assign rem_shift = {rem_r[15:0], dvd_r[28]};
	assign rem_sub   = rem_shift - {1'b0, den_r};

	// speed monitor: serial divider, then saturation and sign
	always_comb begin
		div_state_nxt = div_state_r;
		dvd_nxt       = dvd_r;
		quo_nxt       = quo_r;
		rem_nxt       = rem_r;
		den_nxt       = den_r;
		rev_nxt       = rev_r;
		cnt_nxt       = cnt_r;
		speed_nxt     = motor_speed_monitor_out;
		case (div_state_r)
			drive_serial_pkg::DIV_IDLE: begin
				// sample a fresh operating point every pass
				dvd_nxt       = {motor_freq_in, 13'h0000};
				den_nxt       = rated_motor_frequency_in;
				rev_nxt       = motor_reverse_in;
				quo_nxt       = 29'h00000000;
				rem_nxt       = 17'h00000;
				cnt_nxt       = 5'h00;
				div_state_nxt = drive_serial_pkg::DIV_RUN;
			end
			drive_serial_pkg::DIV_RUN: begin
				dvd_nxt = {dvd_r[27:0], 1'b0};
				if (rem_shift >= {1'b0, den_r}) begin
					rem_nxt = rem_sub;
					quo_nxt = {quo_r[27:0], 1'b1};
				end else begin
					rem_nxt = rem_shift;
					quo_nxt = {quo_r[27:0], 1'b0};
				end
				cnt_nxt = cnt_r + 5'h01;
				if (cnt_r == drive_serial_pkg::DIV_STEPS - 5'h01) begin
					div_state_nxt = drive_serial_pkg::DIV_DONE;
				end
			end
			drive_serial_pkg::DIV_DONE: begin
				// clamp to the 16-bit signed word rather than wrap
				if (den_r == 16'h0000) begin
					speed_nxt = 16'h0000;
				end else if (!rev_r) begin
					if (quo_r > {13'h0000, drive_serial_pkg::SPEED_POS_MAX}) begin
						speed_nxt = drive_serial_pkg::SPEED_POS_MAX;
					end else begin
						speed_nxt = quo_r[15:0];
					end
				end else begin
					if (quo_r > {13'h0000, drive_serial_pkg::SPEED_NEG_MAX}) begin
						speed_nxt = drive_serial_pkg::SPEED_NEG_MAX;
					end else begin
						speed_nxt = 16'h0000 - quo_r[15:0];
					end
				end
				div_state_nxt = drive_serial_pkg::DIV_IDLE;
			end
			default: begin
				div_state_nxt = drive_serial_pkg::DIV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			div_state_r             <= drive_serial_pkg::DIV_IDLE;
			dvd_r                   <= 29'h00000000;
			quo_r                   <= 29'h00000000;
			rem_r                   <= 17'h00000;
			den_r                   <= 16'h0000;
			rev_r                   <= 1'b0;
			cnt_r                   <= 5'h00;
			motor_speed_monitor_out <= drive_serial_pkg::SPEED_RESET;
		end else if (ce_in) begin
			div_state_r             <= div_state_nxt;
			dvd_r                   <= dvd_nxt;
			quo_r                   <= quo_nxt;
			rem_r                   <= rem_nxt;
			den_r                   <= den_nxt;
			rev_r                   <= rev_nxt;
			cnt_r                   <= cnt_nxt;
			motor_speed_monitor_out <= speed_nxt;
		end
	end

	// setpoint magnitude times rated frequency over 8192, no upper clamp
	assign ref_mag  = setpoint_r[15] ? 17'h00000 - {1'b1, setpoint_r}
		: {1'b0, setpoint_r};
	assign ref_prod = 33'({16'h0000, ref_mag} *
		{17'h00000, rated_motor_frequency_in});

	// command decode and reference resolution
	always_comb begin
		logic gate;
		gate           = cmd_source_serial_in;
		run_nxt        = gate && command_r[drive_serial_pkg::BIT_RUN];
		enable_nxt     = gate && command_r[drive_serial_pkg::BIT_ENABLE];
		inching_nxt    = gate && command_r[drive_serial_pkg::BIT_INCHING];
		remote_nxt     = gate && command_r[drive_serial_pkg::BIT_REMOTE];
		ramp2_nxt      = gate && command_r[drive_serial_pkg::BIT_RAMP2];
		// reset acts once each time fault, bit 7 and serial source first coincide, not every cycle the bit stays
		fault_cond_nxt = gate && fault_active_in &&
			command_r[drive_serial_pkg::BIT_FAULT_CLR];
		fault_rst_nxt  = fault_cond_nxt && !fault_cond_r;
		// mirror is the stored word, whatever the command source
		mirror_nxt     = {command_r[drive_serial_pkg::BIT_FAULT_CLR], 1'b0,
			command_r[5:0]};
		// scale: 8192 gives rated; larger magnitudes keep going linearly
		ref_freq_nxt   = ref_prod[30:drive_serial_pkg::SCALE_SHIFT];
		// direction bit inverts the sign meaning
		ref_fwd_nxt    = command_r[drive_serial_pkg::BIT_DIRECTION] ^
			setpoint_r[15];
		ref_valid_nxt  = ref_source_serial_in;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			run_out                  <= 1'b0;
			enable_out               <= 1'b0;
			inching_function_out     <= 1'b0;
			local_remote_select_out  <= 1'b0;
			second_ramp_out          <= 1'b0;
			fault_reset_out          <= 1'b0;
			fault_cond_r             <= 1'b0;
			binary_object_mirror_out <= 8'h00;
			ref_freq_out             <= 18'h00000;
			ref_forward_out          <= 1'b0;
			ref_valid_out            <= 1'b0;
		end else if (ce_in) begin
			run_out                  <= run_nxt;
			enable_out               <= enable_nxt;
			inching_function_out     <= inching_nxt;
			local_remote_select_out  <= remote_nxt;
			second_ramp_out          <= ramp2_nxt;
			fault_reset_out          <= fault_rst_nxt;
			fault_cond_r             <= fault_cond_nxt;
			binary_object_mirror_out <= mirror_nxt;
			ref_freq_out             <= ref_valid_nxt ? ref_freq_nxt : 18'h00000;
			ref_forward_out          <= ref_fwd_nxt;
			ref_valid_out            <= ref_valid_nxt;
		end
	end

	// checks
	a_refused_write_holds: assert property (
		(ce_in && param_wr_in && !param_serial_src_in)
		|=> ($stable(command_r) && $stable(setpoint_r) && param_refused_out))
		else $error("write from non-serial source changed a word");

	a_reserved_bits_zero: assert property (
		(command_r & ~drive_serial_pkg::COMMAND_MASK) == 16'h0000)
		else $error("reserved command bit is set");

	a_reset_clears_cmd: assert property (
		@(posedge clk_in) disable iff (1'b0)
		reset_in |=> (command_r == 16'h0000 && !run_out && !enable_out))
		else $error("command word not cleared by reset");

	a_run_gated_source: assert property (
		ce_in |=> (run_out == $past(command_r[0] && cmd_source_serial_in)
		&& enable_out == $past(command_r[1] && cmd_source_serial_in)))
		else $error("run or enable output not gated by command source");

	a_direction_resolve: assert property (
		ce_in |=> (ref_forward_out == ($past(command_r[2]) ^
		$past(setpoint_r[15]))))
		else $error("effective direction resolved wrongly");

	a_rated_setpoint_scale: assert property (
		(ce_in && ref_source_serial_in && setpoint_r == 16'h2000)
		|=> ref_freq_out == {2'b00, $past(rated_motor_frequency_in)})
		else $error("setpoint 8192 does not give rated frequency");

	a_fault_reset_pulse: assert property (
		(fault_reset_out && ce_in) |=> !fault_reset_out)
		else $error("fault reset lasted more than one cycle");

	a_reverse_is_negative: assert property (
		(ce_in && div_state_r == drive_serial_pkg::DIV_DONE && rev_r &&
		den_r != 16'h0000 && quo_r != 29'h00000000)
		|=> motor_speed_monitor_out[15])
		else $error("reverse motion reported as non-negative");

	a_mirror_tracks_cmd: assert property (
		ce_in |=> binary_object_mirror_out ==
		{$past(command_r[7]), 1'b0, $past(command_r[5:0])})
		else $error("binary object mirror differs from command word");

	a_access_acked: assert property (
		(ce_in && (param_wr_in || param_rd_in)) |=> param_ack_out)
		else $error("parameter access not acknowledged");

endmodule

// File: rtl/drive_serial_pkg.sv
// constants and types for the drive serial command word block
// Functional notes
// - speed monitor is signed, 0 is standstill, 8192 is rated frequency, linear.
// - speed monitor reads negative while the motor turns in reverse.
// - speed monitor is read-only, spanning -32768 to +32767.
// - command word and speed setpoint are writable only from the serial source.
// - command bits act only while command source configuration selects serial; bit 2 sets reference direction whatever the source.
// - bit 0 clear stops on deceleration ramp; set runs up to reference.
// - bit 1 clear disables drive and motor supply; set enables the drive.
// - bit 2 set follows reference direction; clear runs the opposite way.
// - bit 3 enables the inching function while set, disables it while clear.
// - bit 4 clear selects local mode, set selects remote mode.
// - bit 5 clear uses first ramp time pair, set uses the second.
// - bit 7 set during a fault performs a fault reset; clear does nothing.
// - bits 0-5 mirror onto binary objects 16-21, bit 7 onto 23.
// - serial setpoint applies only while reference source selects serial.
// - setpoint is signed, 0 is zero speed, 8192 is rated frequency.
// - setpoint magnitudes above 8192 scale linearly beyond rated frequency.
// - bit 2 set: positive forward, negative reverse; clear inverts both.
package drive_serial_pkg;

	// parameter select codes on the access port
	localparam logic [1:0]  SEL_SPEED_MON  = 2'h0;
	localparam logic [1:0]  SEL_COMMAND    = 2'h1;
	localparam logic [1:0]  SEL_SETPOINT   = 2'h2;

	// reset values and writable bits
	localparam logic [15:0] COMMAND_RESET  = 16'h0000;
	localparam logic [15:0] SETPOINT_RESET = 16'h0000;
	localparam logic [15:0] SPEED_RESET    = 16'h0000;
	localparam logic [15:0] COMMAND_MASK   = 16'h00bf;

	// command word bit positions
	localparam int unsigned BIT_RUN        = 0;
	localparam int unsigned BIT_ENABLE     = 1;
	localparam int unsigned BIT_DIRECTION  = 2;
	localparam int unsigned BIT_INCHING    = 3;
	localparam int unsigned BIT_REMOTE     = 4;
	localparam int unsigned BIT_RAMP2      = 5;
	localparam int unsigned BIT_FAULT_CLR  = 7;

	// 13-bit speed scale
	localparam int unsigned SCALE_SHIFT    = 13;
	localparam logic [15:0] SPEED_RATED    = 16'h2000;
	localparam logic [15:0] SPEED_POS_MAX  = 16'h7fff;
	localparam logic [15:0] SPEED_NEG_MAX  = 16'h8000;
	localparam int unsigned DIVIDEND_W     = 29;
	localparam logic [4:0]  DIV_STEPS      = 5'h1d;

	// speed monitor divider sequence
	typedef enum logic [1:0] {
		DIV_IDLE = 2'b00,
		DIV_RUN  = 2'b01,
		DIV_DONE = 2'b11
	} div_state_e;

endpackage

// File: bench/serial_master_model.sv
// serial master model issuing single word requests to the block
module serial_master_model (
	// clock
	input  wire logic        clk_in,
	// answers from the block
	input  wire logic        ack_in,
	input  wire logic        refused_in,
	input  wire logic [15:0] rdata_in,
	// requests to the block
	output logic             wr_out,
	output logic             rd_out,
	output logic             src_out,
	output logic      [1:0]  sel_out,
	output logic      [15:0] wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		src_out = 1'b1;
		sel_out = 2'h0;
		wdata_out = 16'h0000;
	end

	// one pulse request, then a bounded wait for the answer
	task automatic xfer(input logic w, s, input logic [1:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic r);
		int i;
		q = 16'hxxxx;
		r = 1'bx;
		@(posedge clk_in);
		wr_out <= w;
		rd_out <= !w;
		src_out <= s; // serial or panel origin
		sel_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		wdata_out <= ~d; // a released bus never shows the old word
		for (i = 0; i < 4; i++) begin
			#1;
			if (ack_in === 1'b1) begin
				q = rdata_in;
				r = refused_in;
				break;
			end
			@(posedge clk_in);
		end
	endtask
endmodule

// File: bench/drive_serial_command_words_tb.sv
// self-checking bench for the drive serial command word block
module drive_serial_command_words_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_in = 0, reset_in = 1, ce_in = 1, csrc = 0, rsrc = 0;
	logic rev = 0, flt = 0, rf;
	logic [15:0] freq = 16'h001e, rated = 16'h003c, q;
	logic wr, rd, src, ack, refd, run, en, inch, rem, rmp, frst, fwd, rv;
	logic [1:0] sel;
	logic [15:0] wd, rdat, mon;
	logic [7:0] mir;
	logic [17:0] rff;
	int fails = 0, checks = 0, pulses = 0, i;
	logic [15:0] cw[6] = '{16'h0004, 16'h0004, 16'h0004, 16'h0004,
		16'h0000, 16'h0000};
	logic [15:0] sp[6] = '{16'h1000, 16'hf000, 16'h4000, 16'h0000,
		16'h1000, 16'hf000};
	logic [17:0] ef[6] = '{18'h1e, 18'h1e, 18'h78, 18'h0, 18'h1e, 18'h1e};
	logic ed[6] = '{1, 0, 1, 1, 0, 1};

	// clock
	initial begin
		forever #5 clk_in = ~clk_in;
	end

	drive_serial_command_words uut (
		.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
		.param_wr_in(wr), .param_rd_in(rd), .param_serial_src_in(src),
		.param_sel_in(sel), .param_wdata_in(wd),
		.param_rdata_out(rdat), .param_ack_out(ack),
		.param_refused_out(refd),
		.cmd_source_serial_in(csrc), .ref_source_serial_in(rsrc),
		.motor_freq_in(freq), .motor_reverse_in(rev),
		.rated_motor_frequency_in(rated), .fault_active_in(flt),
		.run_out(run), .enable_out(en), .inching_function_out(inch),
		.local_remote_select_out(rem), .second_ramp_out(rmp),
		.fault_reset_out(frst), .binary_object_mirror_out(mir),
		.ref_freq_out(rff), .ref_forward_out(fwd), .ref_valid_out(rv),
		.motor_speed_monitor_out(mon)
	);

	serial_master_model m (
		.clk_in(clk_in), .ack_in(ack), .refused_in(refd),
		.rdata_in(rdat), .wr_out(wr), .rd_out(rd), .src_out(src),
		.sel_out(sel), .wdata_out(wd)
	);

	// fault reset pulses are counted, not sampled once
	always @(posedge clk_in) begin
		if (frst === 1'b1)
			pulses++;
	end

	task automatic chk(input logic [17:0] g, e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic wrw(input logic s, input logic [1:0] a,
		input logic [15:0] d);
		m.xfer(1'b1, s, a, d, q, rf);
		wait_n(2);
	endtask

	task automatic rdw(input logic [1:0] a);
		m.xfer(1'b0, 1'b1, a, 16'h0000, q, rf);
	endtask

	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog: the tests need well under 2000 cycles
	initial begin
		#50us;
		fails++;
		wrap_up();
	end

	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		rdw(2'h1);
		chk(q, 16'h0000);
		chk({run, en, inch, rem, rmp, frst}, 6'h00);
		$display("test reset done");
		@(posedge clk_in) csrc <= 1'b1;
		wrw(1'b1, 2'h1, 16'hffff);
		chk(rf, 1'b0);
		rdw(2'h1);
		chk(q, 16'h00bf);
		chk(mir, 8'hbf);
		for (i = 0; i < 6; i++) begin
			wrw(1'b1, 2'h1, 16'h0001 << i);
			rdw(2'h1);
			chk(q, 16'h0001 << i);
			// bit 2 is direction only, so of the command outputs only the mirror follows it
			chk({rmp, rem, inch, en, run},
				(i == 2) ? 5'h00 : 5'h01 << (i - (i > 2)));
			chk(mir, 8'h01 << i);
		end
		$display("test command bits done");
		wrw(1'b0, 2'h1, 16'h0013);
		chk(rf, 1'b1);
		wrw(1'b0, 2'h2, 16'h1234);
		chk(rf, 1'b1);
		rdw(2'h1);
		chk(q, 16'h0020);
		wrw(1'b1, 2'h1, 16'h0013);
		@(posedge clk_in) csrc <= 1'b0;
		wait_n(2);
		chk({run, en, rem}, 3'h0);
		chk(mir, 8'h13);
		@(posedge clk_in) csrc <= 1'b1;
		@(posedge clk_in) flt <= 1'b1;
		wait_n(3);
		chk(pulses, 0);
		wrw(1'b1, 2'h1, 16'h0080);
		wait_n(3);
		chk(pulses, 1);
		chk(mir, 8'h80);
		$display("test sources and fault done");
		@(posedge clk_in) rsrc <= 1'b1;
		for (i = 0; i < 6; i++) begin
			wrw(1'b1, 2'h1, cw[i]);
			wrw(1'b1, 2'h2, sp[i]);
			chk(rff, ef[i]);
			chk(fwd, ed[i]);
		end
		wrw(1'b1, 2'h2, 16'h2000);
		chk(rff, 18'h0003c);
		@(posedge clk_in) rsrc <= 1'b0;
		wait_n(2);
		chk({rv, rff}, 19'h0);
		rdw(2'h3);
		chk({rf, q}, 17'h10000);
		$display("test reference done");
		wait_n(70);
		chk(mon, 16'h1000);
		@(posedge clk_in) rev <= 1'b1;
		wait_n(70);
		chk(mon, 16'hf000);
		@(posedge clk_in) freq <= 16'h0258;
		wait_n(70);
		chk(mon, 16'h8000);
		wrw(1'b1, 2'h0, 16'h0001);
		chk(rf, 1'b1);
		rdw(2'h0);
		chk({rf, q}, 17'h08000);
		$display("test monitor done");
		wrap_up();
	end
endmodule
